// ### hdl/lpf_defs.vh
// Offsets, field positions, reset values and ramp durations of the frame control block.
`ifndef LPF_DEFS_VH
`define LPF_DEFS_VH
`define LPF_ADDR_CTRL      8'h15
`define LPF_ADDR_TIMING    8'h16
`define LPF_BIT_SRC        0
`define LPF_BIT_SHAPE      1
`define LPF_CTRL_RST       2'h0
`define LPF_RISE_MSB       7
`define LPF_RISE_LSB       4
`define LPF_FALL_MSB       3
`define LPF_FALL_LSB       0
`define LPF_RISE_RST       4'h8
`define LPF_FALL_RST       4'h8
`define LPF_MS_W           14
`define LPF_MS_0           14'd0
`define LPF_MS_1           14'd120
`define LPF_MS_2           14'd250
`define LPF_MS_3           14'd380
`define LPF_MS_4           14'd510
`define LPF_MS_5           14'd770
`define LPF_MS_6           14'd1000
`define LPF_MS_7           14'd1600
`define LPF_MS_8           14'd2100
`define LPF_MS_9           14'd2600
`define LPF_MS_10          14'd3100
`define LPF_MS_11          14'd4200
`define LPF_MS_12          14'd5200
`define LPF_MS_13          14'd6200
`define LPF_MS_14          14'd7300
`define LPF_MS_15          14'd8300
`endif

// ### hdl/lpf_chan_gate.v
// Per-output frame gate: start lag in frames followed by frame masking.
`timescale 1ns/1ps
module lpf_chan_gate #(
  parameter LAG_W  = 4,
  parameter MASK_W = 3
) (
  input  wire              i_mclk,      // System clock.
  input  wire              i_rst_b,     // Asynchronous reset, active low.
  input  wire              i_run,       // Pattern generation running.
  input  wire              i_frame_end, // One-cycle pulse at each frame end.
  input  wire [LAG_W-1:0]  i_lag,       // Start lag in whole frames.
  input  wire [MASK_W-1:0] i_mask,      // Frames skipped after each played frame.
  output reg               o_play       // Current frame is played.
);

  reg [LAG_W-1:0]  wait_q;
  reg [MASK_W-1:0] skip_q;

  // Lag counts down first, then the mask skips frames; both work together.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_q <= {LAG_W{1'b0}};
      skip_q <= {MASK_W{1'b0}};
      o_play <= 1'b0;
    end else begin
      if (!i_run) begin
        wait_q <= i_lag;
        skip_q <= {MASK_W{1'b0}};
      end else if (i_frame_end) begin
        if (wait_q != {LAG_W{1'b0}}) begin
          wait_q <= wait_q - 1'b1;
        end else if (skip_q != {MASK_W{1'b0}}) begin
          skip_q <= skip_q - 1'b1;
        end else begin
          skip_q <= i_mask;
        end
      end
      o_play <= i_run && (wait_q == {LAG_W{1'b0}}) && (skip_q == {MASK_W{1'b0}});
    end
  end

endmodule

// ### hdl/lpf_frame_ctrl.v
// Frame control top: start lags, frame masks, pin toggle and dimming settings.
`timescale 1ns/1ps
`include "lpf_defs.vh"
module lpf_frame_ctrl #(
  parameter LAG_W = 4,
  parameter MASK_W = 3,
  parameter TOG_W = 4
) (
  input  wire              i_mclk,               // System clock, 25 MHz.
  input  wire              i_rst_b,              // Asynchronous reset, active low.
  input  wire              i_reg_wr,             // Register write strobe.
  input  wire [7:0]        i_reg_addr,           // Register address.
  input  wire [7:0]        i_reg_wdata,          // Register write data.
  output reg  [7:0]        o_reg_rdata,          // Registered read data.
  input  wire              i_pattern_run,        // Pattern generation running.
  input  wire              i_frame_end,          // One-cycle frame end pulse.
  input  wire [LAG_W-1:0]  i_output1_start_lag,  // Start lag of output 1.
  input  wire [LAG_W-1:0]  i_output2_start_lag,  // Start lag of output 2.
  input  wire [LAG_W-1:0]  i_output3_start_lag,  // Start lag of output 3.
  input  wire [LAG_W-1:0]  i_output4_start_lag,  // Start lag of output 4.
  input  wire [MASK_W-1:0] i_output1_mask,       // Frame mask of output 1.
  input  wire [MASK_W-1:0] i_output2_mask,       // Frame mask of output 2.
  input  wire [MASK_W-1:0] i_output3_mask,       // Frame mask of output 3.
  input  wire [MASK_W-1:0] i_output4_mask,       // Frame mask of output 4.
  input  wire              i_toggle_en,          // Pin toggle enable.
  input  wire [TOG_W-1:0]  i_toggle_frames,      // Frames between pin toggles.
  input  wire              i_int_pwm,            // Internal PWM generator level.
  input  wire              i_ramp_up,            // High while ramping up.
  input  wire              i_gpio_in,            // Shared pin input level.
  output reg               o_gpio_out,           // Shared pin output level.
  output reg               o_gpio_oe,            // Shared pin output enable.
  output reg  [3:0]        o_led_output_play,    // Per-output frame play, bit0 output 1.
  output reg               o_dim_pwm,            // Selected dimming PWM level.
  output reg               o_dim_linear,         // Ramp shape, high for linear.
  output reg  [`LPF_MS_W-1:0] o_ramp_ms          // Active ramp duration in ms.
);

  reg  [1:0]       ctrl_q;
  reg  [3:0]       rise_q;
  reg  [3:0]       fall_q;
  reg  [TOG_W-1:0] tog_cnt_q;
  reg  [2:0]       pin_sync_q;
  reg              ext_pwm_q;
  wire [3:0]       play_w;
  wire [3:0]       ramp_code_w;
  reg  [`LPF_MS_W-1:0] ramp_ms_d;
  wire             wr_ctrl_w;
  wire             wr_timing_w;

  // One gate per output, all fed the same frame boundaries.
  // The gates never see the control register or the toggle enable, so lag and mask behave alike in every mode.

  // Gate of output 1.
  lpf_chan_gate #(
    .LAG_W  (LAG_W),
    .MASK_W (MASK_W)
  ) u_gate1 (
    .i_mclk      (i_mclk),
    .i_rst_b     (i_rst_b),
    .i_run       (i_pattern_run),
    .i_frame_end (i_frame_end),
    .i_lag       (i_output1_start_lag),
    .i_mask      (i_output1_mask),
    .o_play      (play_w[0])
  );

  // Gate of output 2.
  lpf_chan_gate #(
    .LAG_W  (LAG_W),
    .MASK_W (MASK_W)
  ) u_gate2 (
    .i_mclk      (i_mclk),
    .i_rst_b     (i_rst_b),
    .i_run       (i_pattern_run),
    .i_frame_end (i_frame_end),
    .i_lag       (i_output2_start_lag),
    .i_mask      (i_output2_mask),
    .o_play      (play_w[1])
  );

  // Gate of output 3.
  lpf_chan_gate #(
    .LAG_W  (LAG_W),
    .MASK_W (MASK_W)
  ) u_gate3 (
    .i_mclk      (i_mclk),
    .i_rst_b     (i_rst_b),
    .i_run       (i_pattern_run),
    .i_frame_end (i_frame_end),
    .i_lag       (i_output3_start_lag),
    .i_mask      (i_output3_mask),
    .o_play      (play_w[2])
  );

  // Gate of output 4.
  lpf_chan_gate #(
    .LAG_W  (LAG_W),
    .MASK_W (MASK_W)
  ) u_gate4 (
    .i_mclk      (i_mclk),
    .i_rst_b     (i_rst_b),
    .i_run       (i_pattern_run),
    .i_frame_end (i_frame_end),
    .i_lag       (i_output4_start_lag),
    .i_mask      (i_output4_mask),
    .o_play      (play_w[3])
  );

  // Write decode; a write to any other address is dropped.
  assign wr_ctrl_w   = i_reg_wr && (i_reg_addr == `LPF_ADDR_CTRL);
  assign wr_timing_w = i_reg_wr && (i_reg_addr == `LPF_ADDR_TIMING);

  // Register writes and registered reads; unmapped addresses read zero.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q      <= `LPF_CTRL_RST;
      rise_q      <= `LPF_RISE_RST;
      fall_q      <= `LPF_FALL_RST;
      o_reg_rdata <= 8'h00;
    end else begin
      if (wr_ctrl_w) begin
        ctrl_q <= i_reg_wdata[`LPF_BIT_SHAPE:`LPF_BIT_SRC];
      end
      if (wr_timing_w) begin
        rise_q <= i_reg_wdata[`LPF_RISE_MSB:`LPF_RISE_LSB];
        fall_q <= i_reg_wdata[`LPF_FALL_MSB:`LPF_FALL_LSB];
      end
      case (i_reg_addr)
        `LPF_ADDR_CTRL:   o_reg_rdata <= {6'h00, ctrl_q};
        `LPF_ADDR_TIMING: o_reg_rdata <= {rise_q, fall_q};
        default:          o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // Pin toggle: counts frames from generation start and inverts at the count.
  // A count of zero acts as one, so the pin never stalls on a bad setting.
  // The pin rests low whenever toggling stops, so the first bank is lit after a restart.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tog_cnt_q  <= {TOG_W{1'b0}};
      o_gpio_out <= 1'b0;
      o_gpio_oe  <= 1'b0;
    end else begin
      o_gpio_oe <= i_toggle_en;
      if (!i_toggle_en || !i_pattern_run) begin
        tog_cnt_q  <= {TOG_W{1'b0}};
        o_gpio_out <= 1'b0;
      end else if (i_frame_end) begin
        if (tog_cnt_q + 1'b1 >= i_toggle_frames) begin
          tog_cnt_q  <= {TOG_W{1'b0}};
          o_gpio_out <= ~o_gpio_out;
        end else begin
          tog_cnt_q <= tog_cnt_q + 1'b1;
        end
      end
    end
  end

  // Three-stage pin synchroniser; the level changes once stages two and three agree.
  // Waiting for agreement keeps a metastable first stage from reaching the dimming path.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_sync_q <= 3'h0;
      ext_pwm_q  <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], i_gpio_in};
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        ext_pwm_q <= pin_sync_q[2];
      end
    end
  end

  // Rise or fall speed field chosen by ramp direction, decoded to milliseconds.
  assign ramp_code_w = i_ramp_up ? rise_q : fall_q;

  always @* begin
    case (ramp_code_w)
      4'h0:    ramp_ms_d = `LPF_MS_0;
      4'h1:    ramp_ms_d = `LPF_MS_1;
      4'h2:    ramp_ms_d = `LPF_MS_2;
      4'h3:    ramp_ms_d = `LPF_MS_3;
      4'h4:    ramp_ms_d = `LPF_MS_4;
      4'h5:    ramp_ms_d = `LPF_MS_5;
      4'h6:    ramp_ms_d = `LPF_MS_6;
      4'h7:    ramp_ms_d = `LPF_MS_7;
      4'h8:    ramp_ms_d = `LPF_MS_8;
      4'h9:    ramp_ms_d = `LPF_MS_9;
      4'ha:    ramp_ms_d = `LPF_MS_10;
      4'hb:    ramp_ms_d = `LPF_MS_11;
      4'hc:    ramp_ms_d = `LPF_MS_12;
      4'hd:    ramp_ms_d = `LPF_MS_13;
      4'he:    ramp_ms_d = `LPF_MS_14;
      default: ramp_ms_d = `LPF_MS_15;
    endcase
  end

  // Registered outputs of the dimming path and the frame gates.
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dim_pwm         <= 1'b0;
      o_dim_linear      <= 1'b0;
      o_ramp_ms         <= `LPF_MS_0;
      o_led_output_play <= 4'h0;
    end else begin
      o_dim_pwm         <= ctrl_q[`LPF_BIT_SRC] ? ext_pwm_q : i_int_pwm;
      o_dim_linear      <= ctrl_q[`LPF_BIT_SHAPE];
      o_ramp_ms         <= ramp_ms_d;
      o_led_output_play <= play_w;
    end
  end

endmodule

// ### dv/lpf_bank_switch.sv
// Model of the external switch transistors that pick one of two LED banks.
`timescale 1ns/1ps
module lpf_bank_switch (
  input  wire i_pin_out,   // Level driven by the block.
  input  wire i_pin_oe,    // High while the block drives the pin.
  input  wire i_ext_pwm,   // External PWM source seen while the block is not driving.
  output wire o_pin_level, // Resolved pin level.
  output wire o_bank_a_on, // First bank enabled.
  output wire o_bank_b_on  // Second bank enabled.
);
  // While the block drives the pin its level selects exactly one bank; with the pin not driven neither bank lights.
  assign o_pin_level = i_pin_oe ? i_pin_out : i_ext_pwm;
  assign o_bank_a_on = i_pin_oe & ~o_pin_level;
  assign o_bank_b_on = i_pin_oe & o_pin_level;
endmodule

// ### dv/lpf_frame_ctrl_monitor.sv
// Port checks for the frame control block.
`timescale 1ns/1ps
`include "lpf_defs.vh"
module lpf_frame_ctrl_monitor #(
  parameter TOG_W = 4
) (
  input wire                 i_mclk,          // Clock.
  input wire                 i_rst_b,         // Reset.
  input wire                 i_reg_wr,        // Write strobe.
  input wire [7:0]           i_reg_addr,      // Address.
  input wire [7:0]           i_reg_wdata,     // Write data.
  input wire [7:0]           o_reg_rdata,     // Read data.
  input wire                 i_pattern_run,   // Run level.
  input wire                 i_frame_end,     // Frame end.
  input wire                 i_toggle_en,     // Toggle enable.
  input wire [TOG_W-1:0]     i_toggle_frames, // Toggle count.
  input wire                 i_ramp_up,       // Ramp up.
  input wire                 o_gpio_out,      // Pin level.
  input wire                 o_gpio_oe,       // Pin enable.
  input wire                 o_dim_linear,    // Ramp shape.
  input wire [`LPF_MS_W-1:0] o_ramp_ms        // Ramp time.
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);
  // Register, ramp and pin relations with their exact latencies.
  a_ctrl_upper_zero:
    assert property (i_reg_addr == 8'h15 |=> o_reg_rdata[7:2] == 6'h00) else $error("bits set");
  a_shape_follows:
    assert property (i_reg_wr && i_reg_addr == 8'h15 |-> ##2 o_dim_linear == $past(i_reg_wdata[1], 2))
      else $error("shape wrong");
  a_rise_code_max:
    assert property ((i_reg_wr && i_reg_addr == 8'h16 && i_reg_wdata[7:4] == 4'hf) ##1
      (!i_reg_wr throughout (##[0:8] i_ramp_up)) |=> o_ramp_ms == 14'd8300) else $error("rise");
  a_fall_code_zero:
    assert property ((i_reg_wr && i_reg_addr == 8'h16 && i_reg_wdata[3:0] == 4'h0) ##1
      !i_ramp_up |=> o_ramp_ms == 14'd0) else $error("fall");
  a_pin_off_disabled:
    assert property (!i_toggle_en |=> !o_gpio_oe && !o_gpio_out) else $error("pin driven");
  a_pin_low_stopped:
    assert property (!i_pattern_run |=> !o_gpio_out) else $error("pin high");
  a_pin_holds_level:
    assert property (i_toggle_en && i_pattern_run && !i_frame_end |=> $stable(o_gpio_out))
      else $error("pin moved");
  a_toggle_each_frame:
    assert property (i_toggle_en && i_pattern_run && i_frame_end && i_toggle_frames == 1
      |=> o_gpio_out != $past(o_gpio_out)) else $error("no toggle");
endmodule
bind lpf_frame_ctrl lpf_frame_ctrl_monitor #(.TOG_W(TOG_W)) i_lpf_frame_ctrl_monitor (.*);

// ### dv/lpf_frame_ctrl_tb_top.sv
// Self-checking bench for the frame control block.
`timescale 1ns/1ps
module lpf_frame_ctrl_tb_top;
  reg         i_mclk, i_rst_b, i_reg_wr, i_pattern_run, i_frame_end, i_toggle_en;
  reg         i_int_pwm, i_ramp_up, ext_pwm, e;
  reg  [7:0]  i_reg_addr, i_reg_wdata;
  reg  [3:0]  i_toggle_frames, e4;
  reg  [3:0]  lag_v [0:3];
  reg  [2:0]  mask_v [0:3];
  wire [7:0]  o_reg_rdata;
  wire [13:0] o_ramp_ms;
  wire [3:0]  o_led_output_play;
  wire        o_gpio_out, o_gpio_oe, o_dim_pwm, o_dim_linear, pin, bank_a, bank_b;
  integer     n_errors, comparisons, k, j;
  // Design and switch model share the resolved pin.
  lpf_frame_ctrl i_lpf_frame_ctrl (.*, .i_gpio_in(pin), .i_output1_start_lag(lag_v[0]),
    .i_output2_start_lag(lag_v[1]), .i_output3_start_lag(lag_v[2]),
    .i_output4_start_lag(lag_v[3]), .i_output1_mask(mask_v[0]), .i_output2_mask(mask_v[1]),
    .i_output3_mask(mask_v[2]), .i_output4_mask(mask_v[3]));
  lpf_bank_switch i_lpf_bank_switch (.i_pin_out(o_gpio_out), .i_pin_oe(o_gpio_oe),
    .i_ext_pwm(ext_pwm), .o_pin_level(pin), .o_bank_a_on(bank_a), .o_bank_b_on(bank_b));
  // Clock of 40 ns period.
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  // Compares one result and counts the outcome.
  task chk(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task final_report;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // One-cycle register write.
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge i_mclk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_mclk);
      i_reg_wr <= 1'b0;
    end
  endtask
  // Register read; data is valid one edge after the address.
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge i_mclk);
      i_reg_addr <= a;
      @(posedge i_mclk);
      #1 chk(o_reg_rdata, exp);
    end
  endtask
  // Writes the timing register and checks both ramp directions.
  task ramp(input [7:0] v, input [13:0] r, input [13:0] f);
    begin
      wr(8'h16, v);
      repeat (3) @(posedge i_mclk);
      #1 chk(o_ramp_ms, f);
      @(posedge i_mclk);
      i_ramp_up <= 1'b1;
      repeat (3) @(posedge i_mclk);
      #1 chk(o_ramp_ms, r);
      @(posedge i_mclk);
      i_ramp_up <= 1'b0;
    end
  endtask
  // Runs twelve frames and checks play, pin and bank selection in each.
  task frames(input en, input [3:0] t);
    begin
      @(posedge i_mclk); // Lets the gates load fresh lags while run is still low.
      i_toggle_en <= en;
      i_toggle_frames <= t;
      i_pattern_run <= 1'b1;
      for (k = 0; k < 12; k = k + 1) begin
        repeat (6) @(posedge i_mclk);
        #1;
        for (j = 0; j < 4; j = j + 1)
          e4[j] = k >= lag_v[j] && (k - lag_v[j]) % (mask_v[j] + 1) == 0;
        e = en & ((k / t) % 2 == 1);
        chk(o_led_output_play, e4);
        chk({o_gpio_oe, o_gpio_out}, {en, e});
        chk({bank_a, bank_b}, {en & ~e, e});
        @(posedge i_mclk);
        i_frame_end <= 1'b1;
        @(posedge i_mclk);
        i_frame_end <= 1'b0;
      end
      i_pattern_run <= 1'b0;
      repeat (4) @(posedge i_mclk);
    end
  endtask
  // Waits a bounded time for the selected PWM level.
  task wpwm(input v);
    begin
      for (j = 0; j < 10 && o_dim_pwm !== v; j = j + 1) begin
        @(posedge i_mclk);
        #1;
      end
      chk(o_dim_pwm, v);
      if (o_dim_pwm !== v)
        final_report;
    end
  endtask
  // Main sequence.
  initial begin
    n_errors = 0;
    comparisons = 0;
    {i_rst_b, i_reg_wr, i_pattern_run, i_frame_end, i_toggle_en, i_int_pwm, i_ramp_up} = 7'h00;
    ext_pwm = 1'b0;
    {i_reg_addr, i_reg_wdata, i_toggle_frames} = 20'h00001;
    for (j = 0; j < 4; j = j + 1) begin
      lag_v[j] = 4'(j);
      mask_v[j] = 3'h3;
    end
    repeat (5) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h88);
    wr(8'h15, 8'hfe);
    rd(8'h15, 8'h02);
    chk(o_dim_linear, 1'b1);
    wr(8'h20, 8'h5a);
    rd(8'h20, 8'h00);
    rd(8'h16, 8'h88);
    ramp(8'hf0, 14'd8300, 14'd0);
    ramp(8'h0f, 14'd0, 14'd8300);
    ramp(8'h21, 14'd250, 14'd120);
    frames(1'b1, 4'h1);
    for (j = 0; j < 4; j = j + 1) begin
      lag_v[j] <= 4'((4 - j) % 4);
      mask_v[j] <= 3'(j + j / 3);
    end
    frames(1'b1, 4'h3);
    frames(1'b0, 4'h1);
    wr(8'h15, 8'h01);
    ext_pwm <= 1'b1;
    wpwm(1'b1);
    ext_pwm <= 1'b0;
    wpwm(1'b0);
    wr(8'h15, 8'h00);
    i_int_pwm <= 1'b1;
    wpwm(1'b1);
    final_report;
  end
endmodule
